// File: lcdm_top.sv
// Purpose: Duty selection, display memory access and memory-to-pin mapping
// Assumes: Register port strobes are one cycle; read data valid one cycle later
// Notes: seg_on and com_act are logical pixel levels, not drive voltages
//
// Decided for this implementation: the register offsets and the strobed register port.

// ----------------------------------------
// Contract
// ----------------------------------------
module lcdm_top import lcdm_pkg::*; #(
  parameter bit LARGE = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Panel side
  output logic [7:0] com_act,
  output logic [55:0] seg_on,
  output logic shared_com,
  output logic com_static,
  output logic drive_en,
  // Frame interrupt
  output logic frame_irq
);
  typedef struct packed {
    logic [7:0] dctl;
    logic [7:0] cctl;
    logic ie;
    logic flag;
    logic [7:0] rdata;
    logic [7:0] com_act;
    logic [55:0] seg_on;
    logic shared_com;
    logic com_static;
    logic drive_en;
    logic irq;
  } lcdm_state_type;

  lcdm_state_type s_q, s_d;
  logic [RAM_DEPTH-1:0][7:0] view;
  logic [2:0] phase;
  logic frame_pulse;
  logic in_ram;
  logic ram_ok;
  logic ram_wr;
  logic [5:0] idx;
  logic [5:0] nbytes;
  logic [5:0] nseg;
  logic [2:0] duty;
  logic [1:0] dstate;
  logic eighth;
  logic known;
  logic [3:0] ncom;
  logic [2:0] bsel;
  logic [5:0] bidx;
  logic pix;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  assign idx = addr[5:0];
  assign in_ram = (addr[15:6] == ADDR_RAM[15:6]);
  assign nbytes = LARGE ? RAM_LARGE : RAM_SMALL;
  assign ram_ok = in_ram && (idx < nbytes);
  assign ram_wr = wr && ram_ok;
  assign duty = s_q.cctl[2:0];
  assign dstate = s_q.dctl[1:0];
  assign eighth = (duty == DUTY_EIGHTH);

  lcdm_ram u_ram (
    .clk(clk),
    .srst(srst),
    .wr_en(ram_wr),
    .wr_idx(idx),
    .wr_data(wdata),
    .view(view)
  );

  lcdm_scan u_scan (
    .clk(clk),
    .srst(srst),
    .duty(duty),
    .frame_count(s_q.cctl[CCTL_FCNT +: 2]),
    .phase(phase),
    .frame_pulse(frame_pulse)
  );

  // ----------------------------------------
  // Duty decode
  // ----------------------------------------
  always_comb begin
    known = 1'b1;
    case (duty)
      DUTY_EIGHTH: ncom = 4'h8;
      DUTY_QUARTER: ncom = 4'h4;
      DUTY_THIRD: ncom = 4'h3;
      DUTY_HALF: ncom = 4'h2;
      DUTY_STATIC: ncom = 4'h1;
      default: begin
        ncom = 4'h1;
        known = 1'b0;
      end
    endcase
    // Fewer segment bytes in eighth duty; the rest become storage
    if (eighth) begin
      nseg = LARGE ? SEG8_LARGE : SEG8_SMALL;
    end else begin
      nseg = nbytes;
    end
    // Bit feeding the current common, offset by the chosen area except in eighth duty
    bsel = s_q.dctl[DCTL_COMN] ? phase : 3'(ncom - 4'h1 - {1'b0, phase});
    if (!eighth && s_q.dctl[DCTL_AREA]) begin
      bsel = bsel + 3'h4;
    end
  end

  // ----------------------------------------
  // Register update and pixel mapping
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    bidx = '0;
    pix = 1'b0;
    // Registers
    if (wr) begin
      if (addr == ADDR_DCTL) begin
        s_d.dctl = wdata & 8'hf3;
      end else if (addr == ADDR_CCTL) begin
        s_d.cctl = wdata & 8'h37;
      end else if (addr == ADDR_IMSK) begin
        s_d.ie = wdata[0];
      end else if (addr == ADDR_IFLG && wdata[0]) begin
        s_d.flag = 1'b0;
      end
    end
    // A frame in the clearing cycle is kept
    if (frame_pulse) begin
      s_d.flag = 1'b1;
    end
    s_d.irq = s_q.flag && s_q.ie;
    // Read data, zero for unmapped and unavailable addresses
    s_d.rdata = 8'h00;
    if (rd) begin
      if (addr == ADDR_DCTL) begin
        s_d.rdata = s_q.dctl;
      end else if (addr == ADDR_CCTL) begin
        s_d.rdata = s_q.cctl;
      end else if (addr == ADDR_IMSK) begin
        s_d.rdata = {7'h00, s_q.ie};
      end else if (addr == ADDR_IFLG) begin
        s_d.rdata = {7'h00, s_q.flag};
      end else if (ram_ok) begin
        s_d.rdata = view[idx];
      end
    end
    // Panel outputs; reserved duty codes blank the panel
    s_d.drive_en = (dstate != DSP_OFF) && known;
    s_d.com_static = (dstate == DSP_ALL_OFF);
    s_d.shared_com = eighth;
    s_d.com_act = 8'h00;
    if (s_d.drive_en && !s_d.com_static) begin
      s_d.com_act = 8'h01 << phase;
    end
    for (int s = 0; s < 56; s++) begin
      s_d.seg_on[s] = 1'b0;
      if (6'(s) < nseg && s_d.drive_en) begin
        bidx = s_q.dctl[DCTL_SEGN] ? 6'(s) : 6'(nseg - 6'h1 - 6'(s));
        pix = view[bidx][bsel];
        if (dstate == DSP_ALL_ON) begin
          pix = 1'b1;
        end
        if (dstate == DSP_ALL_OFF) begin
          pix = 1'b0;
        end else if (!s_q.dctl[DCTL_INVN]) begin
          pix = !pix;
        end
        s_d.seg_on[s] = pix;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q.dctl <= DCTL_RST;
      s_q.cctl <= CCTL_RST;
      s_q.ie <= 1'b0;
      s_q.flag <= 1'b0;
      s_q.rdata <= 8'h00;
      s_q.com_act <= 8'h00;
      s_q.seg_on <= '0;
      s_q.shared_com <= 1'b0;
      s_q.com_static <= 1'b0;
      s_q.drive_en <= 1'b0;
      s_q.irq <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign com_act = s_q.com_act;
  assign seg_on = s_q.seg_on;
  assign shared_com = s_q.shared_com;
  assign com_static = s_q.com_static;
  assign drive_en = s_q.drive_en;
  assign frame_irq = s_q.irq;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_duty_reset: assert property (@(posedge clk) srst |=> duty == DUTY_EIGHTH)
    else $error("duty not eighth after reset");
  chk_flag_set: assert property (@(posedge clk) disable iff (srst)
    frame_pulse |=> s_q.flag)
    else $error("frame flag lost");
  chk_irq_raise: assert property (@(posedge clk) disable iff (srst)
    frame_pulse && s_q.ie && !wr |=> ##1 frame_irq)
    else $error("frame interrupt missing");
  chk_unavail_read: assert property (@(posedge clk) disable iff (srst)
    rd && in_ram && !ram_ok |=> rdata == 8'h00)
    else $error("unavailable byte read nonzero");
  chk_ram_rmw: assert property (@(posedge clk) disable iff (srst)
    (ram_wr ##1 (rd && addr == $past(addr))) |=> rdata == $past(wdata, 2))
    else $error("display memory readback wrong");
  chk_off_blank: assert property (@(posedge clk) disable iff (srst)
    dstate == DSP_OFF |=> seg_on == '0 && com_act == 8'h00 && !drive_en)
    else $error("display off still drives");
  chk_shared_eighth: assert property (@(posedge clk) disable iff (srst)
    eighth |=> seg_on[55:52] == 4'h0 && shared_com)
    else $error("shared pins drive segments in eighth duty");
  chk_all_off: assert property (@(posedge clk) disable iff (srst)
    dstate == DSP_ALL_OFF |=> com_static && seg_on == '0)
    else $error("all off shows pixels");
  chk_com_onehot: assert property (@(posedge clk) disable iff (srst)
    !com_static |-> $onehot0(com_act))
    else $error("more than one common active");
endmodule

// File: lcdm_pkg.sv
// Purpose: Shared constants for the segment LCD duty and display memory mapper
// Assumes: 8-bit register port, 100 MHz clock, LCD clock emulated by an enable
// Notes: Register offsets are byte addresses on the register port
package lcdm_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int LCLK_HZ = 32768;
  localparam int LCLK_DIV = CLK_HZ / LCLK_HZ;
  localparam logic [11:0] LCLK_DIV_M1 = 12'(LCLK_DIV - 1);

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [15:0] ADDR_DCTL = 16'h50a0;
  localparam logic [15:0] ADDR_CCTL = 16'h50a2;
  localparam logic [15:0] ADDR_IMSK = 16'h50a5;
  localparam logic [15:0] ADDR_IFLG = 16'h50a6;
  localparam logic [15:0] ADDR_RAM = 16'h53c0;
  localparam logic [7:0] DCTL_RST = 8'hd0;
  localparam logic [7:0] CCTL_RST = 8'h14;
  localparam int DCTL_SEGN = 7;
  localparam int DCTL_COMN = 6;
  localparam int DCTL_AREA = 5;
  localparam int DCTL_INVN = 4;
  localparam int CCTL_FCNT = 4;

  // ----------------------------------------
  // Memory and pin counts
  // ----------------------------------------
  localparam int RAM_DEPTH = 56;
  localparam logic [5:0] RAM_LARGE = 6'h38;
  localparam logic [5:0] RAM_SMALL = 6'h28;
  localparam logic [5:0] SEG8_LARGE = 6'h34;
  localparam logic [5:0] SEG8_SMALL = 6'h24;

  // ----------------------------------------
  // Field codes
  // ----------------------------------------
  localparam logic [2:0] DUTY_EIGHTH = 3'h4;
  localparam logic [2:0] DUTY_QUARTER = 3'h3;
  localparam logic [2:0] DUTY_THIRD = 3'h2;
  localparam logic [2:0] DUTY_HALF = 3'h1;
  localparam logic [2:0] DUTY_STATIC = 3'h0;
  localparam logic [1:0] DSP_ALL_OFF = 2'h3;
  localparam logic [1:0] DSP_ALL_ON = 2'h2;
  localparam logic [1:0] DSP_NORMAL = 2'h1;
  localparam logic [1:0] DSP_OFF = 2'h0;

  // Frame length in LCD clocks per frame_count code, and the 1/3 duty table
  localparam logic [10:0] FRAME_LEN [4] = '{11'h100, 11'h200, 11'h2a8, 11'h400};
  localparam logic [10:0] FRAME_LEN3 [4] = '{11'h0fc, 11'h1f8, 11'h2a9, 11'h3f0};
endpackage

// File: lcdm_ram.sv
// Purpose: Display memory, every byte visible in parallel for the scanner
// Assumes: Single write port; reads are taken from the parallel view
// Notes: Contents clear on reset so the panel starts blank
module lcdm_ram import lcdm_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Write port
  input wire logic wr_en,
  input wire logic [5:0] wr_idx,
  input wire logic [7:0] wr_data,
  // Parallel view
  output logic [RAM_DEPTH-1:0][7:0] view
);
  typedef struct packed {
    logic [RAM_DEPTH-1:0][7:0] mem;
  } lcdm_ram_state_type;

  lcdm_ram_state_type s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (wr_en && (wr_idx < 6'(RAM_DEPTH))) begin
      s_d.mem[wr_idx] = wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign view = s_q.mem;
endmodule

// File: lcdm_scan.sv
// Purpose: LCD clock enable, common phase counter and frame pulse
// Assumes: Duty and frame_count may change at any time
// Notes: A phase beyond the new common count restarts the frame
module lcdm_scan import lcdm_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Settings
  input wire logic [2:0] duty,
  input wire logic [1:0] frame_count,
  // Scan state
  output logic [2:0] phase,
  output logic frame_pulse
);
  typedef struct packed {
    logic [11:0] div;
    logic [10:0] lcnt;
    logic [2:0] ph;
    logic frm;
  } lcdm_scan_state_type;

  lcdm_scan_state_type s_q, s_d;
  logic [10:0] plen;
  logic [2:0] last_ph;

  always_comb begin
    plen = FRAME_LEN[frame_count];
    last_ph = 3'h0;
    case (duty)
      DUTY_EIGHTH: begin
        plen = FRAME_LEN[frame_count] >> 3;
        last_ph = 3'h7;
      end
      DUTY_QUARTER: begin
        plen = FRAME_LEN[frame_count] >> 2;
        last_ph = 3'h3;
      end
      DUTY_THIRD: begin
        plen = 11'(FRAME_LEN3[frame_count] / 11'h3);
        last_ph = 3'h2;
      end
      DUTY_HALF: begin
        plen = FRAME_LEN[frame_count] >> 1;
        last_ph = 3'h1;
      end
      default: begin
        plen = FRAME_LEN[frame_count];
        last_ph = 3'h0;
      end
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.frm = 1'b0;
    if (s_q.ph > last_ph) begin
      s_d.ph = 3'h0;
      s_d.lcnt = '0;
    end else if (s_q.div == LCLK_DIV_M1) begin
      s_d.div = '0;
      if (s_q.lcnt >= plen - 11'h1) begin
        s_d.lcnt = '0;
        if (s_q.ph == last_ph) begin
          s_d.ph = 3'h0;
          s_d.frm = 1'b1;
        end else begin
          s_d.ph = s_q.ph + 3'h1;
        end
      end else begin
        s_d.lcnt = s_q.lcnt + 11'h1;
      end
    end else begin
      s_d.div = s_q.div + 12'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign phase = s_q.ph;
  assign frame_pulse = s_q.frm;
endmodule

// File: lcdm_panel.sv
// Purpose: Panel stand-in that latches the row shown on common 0
// Assumes: Logical pixel levels, one active common at a time
// Notes: An undriven row reads dark, never a stale pattern
module lcdm_panel (
  // Clock
  input wire logic clk,
  // Panel pins
  input wire logic [7:0] com_act,
  input wire logic [55:0] seg_on,
  input wire logic drive_en,
  // Observed row
  output logic [55:0] row0_q
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Row capture
  // ----------------------------------------
  always @(posedge clk) begin
    if (drive_en && com_act[0]) begin
      row0_q <= seg_on;
    end else begin
      row0_q <= '0;
    end
  end
endmodule

// File: test_lcd_duty_memory_mapper.sv
// Purpose: Register, memory and mapping checks on both size variants
// Assumes: Run stays inside the first scan phase, so common 0 is active
// Notes: Frame timing is far too long to reach here; only its registers
module test_lcd_duty_memory_mapper import lcdm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] addr = '0;
  logic [7:0] wdata = '0;
  logic [7:0] rd_l, rd_s, com_l, com_s;
  logic [55:0] seg_l, seg_s, row_l, row_s;
  logic sh_l, sh_s, cs_l, cs_s, en_l, en_s, irq_l, irq_s;
  logic [7:0] mem [56];
  int n_mismatch = 0;
  int comparisons = 0;

  always #5 clk = ~clk;

  lcdm_top #(.LARGE(1'b1)) dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rd_l), .com_act(com_l), .seg_on(seg_l), .shared_com(sh_l),
    .com_static(cs_l), .drive_en(en_l), .frame_irq(irq_l));
  lcdm_top #(.LARGE(1'b0)) dut_small (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rd_s), .com_act(com_s), .seg_on(seg_s), .shared_com(sh_s),
    .com_static(cs_s), .drive_en(en_s), .frame_irq(irq_s));
  lcdm_panel pan_l (.clk(clk), .com_act(com_l), .seg_on(seg_l), .drive_en(en_l), .row0_q(row_l));
  lcdm_panel pan_s (.clk(clk), .com_act(com_s), .seg_on(seg_s), .drive_en(en_s), .row0_q(row_s));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_b(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_b(input logic [15:0] a, input logic [7:0] el, input logic [7:0] es);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rd_l, el);
    chk(rd_s, es);
  endtask

  function automatic logic [55:0] msk(input bit lg, input logic [2:0] d);
    int ns;
    ns = lg ? (d == 3'h4 ? 52 : 56) : (d == 3'h4 ? 36 : 40);
    return 56'((57'h1 << ns) - 57'h1);
  endfunction

  // Expected row on common 0 from the shadow memory
  function automatic logic [55:0] exp_row(input bit lg, input logic [2:0] d, input logic [7:0] c);
    int n, ns, b;
    logic [55:0] r;
    n = (d == 3'h4) ? 8 : int'(d) + 1;
    ns = lg ? (d == 3'h4 ? 52 : 56) : (d == 3'h4 ? 36 : 40);
    b = c[6] ? 0 : n - 1;
    if (c[5] && d != 3'h4) b += 4;
    r = '0;
    for (int s = 0; s < ns; s++) r[s] = mem[c[7] ? s : ns - 1 - s][b];
    if (c[1:0] == 2'h2) r = msk(lg, d);
    if (c[1:0] == 2'h0 || c[1:0] == 2'h3) return '0;
    if (!c[4]) r = ~r & msk(lg, d);
    return r;
  endfunction

  // Panel lags control by write, register and capture stages
  task automatic show(input logic [7:0] c, input logic [2:0] d);
    wr_b(ADDR_DCTL, c);
    repeat (4) @(posedge clk);
    #1;
    chk(cs_l, c[1:0] == 2'h3);
    chk(cs_s, c[1:0] == 2'h3);
    chk(row_l & msk(1'b1, d), exp_row(1'b1, d, c));
    chk(row_s & msk(1'b0, d), exp_row(1'b0, d, c));
  endtask

  task automatic wrap_up();
    $display("TB: comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    for (int i = 0; i < 56; i++) mem[i] = 8'(i * 29 + 91);
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    chk(en_l, 1'b0);
    rd_b(ADDR_DCTL, 8'hd0, 8'hd0);
    rd_b(ADDR_CCTL, 8'h14, 8'h14);
    // Full sweep past the end, so ignored writes show as zeros
    for (int i = 0; i < 64; i++) wr_b(ADDR_RAM + 16'(i), i < 56 ? mem[i] : 8'hff);
    for (int i = 0; i < 64; i++) begin
      rd_b(ADDR_RAM + 16'(i), i < 56 ? mem[i] : 8'h00, i < 40 ? mem[i] : 8'h00);
    end
    wr_b(ADDR_DCTL, 8'hd1);
    for (int d = 7; d >= 0; d--) begin
      wr_b(ADDR_CCTL, 8'h10 | 8'(d));
      rd_b(ADDR_CCTL, 8'h10 | 8'(d), 8'h10 | 8'(d));
      #10;
      chk(en_l, d < 5);
      chk(sh_l, d == 4);
      chk(sh_s, d == 4);
      chk(com_l, d < 5 ? 8'h01 : 8'h00);
      chk(en_s, d < 5);
      chk(com_s, d < 5 ? 8'h01 : 8'h00);
    end
    for (int d = 4; d >= 0; d--) begin
      wr_b(ADDR_CCTL, 8'h10 | 8'(d));
      for (int c = 0; c < 8; c++) begin
        show(8'h11 | 8'(c << 5), 3'(d));
      end
    end
    for (int s = 0; s < 8; s++) show(8'hc0 | (s[0] ? 8'h10 : 8'h00) | 8'(s >> 1), 3'h0);
    rd_b(ADDR_RAM + 16'h0037, mem[55], 8'h00);
    wr_b(ADDR_IMSK, 8'h01);
    rd_b(ADDR_IMSK, 8'h01, 8'h01);
    rd_b(ADDR_IFLG, 8'h00, 8'h00);
    chk(irq_l, 1'b0);
    chk(irq_s, 1'b0);
    wrap_up();
  end
endmodule
